// >>> logic/dmz_mode_ctl.sv
`timescale 1ns/10ps
`include "dmz_defs.svh"

module dmz_mode_ctl #(
    parameter int TMRD_CK = `DMZ_TMRD_CK,
    parameter int TMOD_CK = `DMZ_TMOD_CK,
    parameter int TZQINIT_CK = `DMZ_TZQINIT_CK,
    parameter int TZQOPER_CK = `DMZ_TZQOPER_CK,
    parameter int TZQCS_CK = `DMZ_TZQCS_CK
) (
    input wire logic clk,
    input wire logic rst,
    input wire dmz_pkg::dmz_cmd_t cmd,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic [4:0] rl_cycles,
    input wire logic dq_ready,
    output logic [13:0] mr0_q,
    output logic [13:0] mr1_q,
    output logic [13:0] mr2_q,
    output logic [13:0] mr3_q,
    output logic mode_busy_q,
    output logic zq_busy_q,
    output logic array_rd_q,
    output logic cmd_err_q,
    output logic [7:0] dq_q,
    output logic dq_valid_q
);
    import dmz_pkg::*;

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // Counters are ten bits wide; a zero count would never expire cleanly
    if (TMRD_CK < 1 || TMRD_CK > 1023 || TMOD_CK < 1 || TMOD_CK > 1023 ||
        TZQINIT_CK < 1 || TZQINIT_CK > 1023 || TZQOPER_CK < 1 ||
        TZQOPER_CK > 1023 || TZQCS_CK < 1 || TZQCS_CK > 1023) begin : g_bad_timing
        $error("dmz_mode_ctl: timing count out of range");
    end

    // Saturating down count shared by the mode and calibration timers
    function automatic logic [9:0] dec_sat(input logic [9:0] c);
        dec_sat = (c == 10'h000) ? 10'h000 : c - 10'h001;
    endfunction

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic [9:0] mrd_cnt_q; // Command lockout after a mode set
    logic [9:0] mod_cnt_q; // Delay until the staged value takes effect
    logic [9:0] zq_cnt_q; // Quiet interval of impedance calibration
    logic [1:0] pend_sel_q; // Register waiting for its update
    logic [13:0] pend_val_q; // Value waiting for its update
    logic zq_init_done_q; // First long calibration already run
    dmz_state_t st_q; // Burst generator state
    logic [4:0] rl_cnt_q; // Read latency countdown
    logic [2:0] beat_q; // Burst position being produced
    logic [2:0] last_q; // Final burst position of this read
    logic skid_v_q; // Second buffer entry occupied
    logic [7:0] skid_q; // Second buffer entry data

    wire is_nop = (cmd == DMZ_CMD_NOP);
    wire is_read = (cmd == DMZ_CMD_READ) || (cmd == DMZ_CMD_RDAP);
    wire is_zq = (cmd == DMZ_CMD_ZQCL) || (cmd == DMZ_CMD_ZQCS);
    wire is_mrs = (cmd == DMZ_CMD_MRS);
    wire mpr_on = mr3_q[`DMZ_MPR_EN_BIT];
    wire pat_ok = (mr3_q[1:0] == `DMZ_MPR_SEL_PAT);
    // Anything other than a read, mode set or no-op is refused in pattern mode
    wire mpr_viol = mpr_on && !is_read && !is_mrs;
    // Only no-ops and further calibration commands may share the quiet interval
    wire zq_viol = (zq_cnt_q != 10'h000) && !is_zq;
    wire quiet_viol = !is_nop && ((mrd_cnt_q != 10'h000) || zq_viol || mpr_viol);
    wire cmd_ok = !quiet_viol;
    wire mrs_go = is_mrs && !ba[2] && cmd_ok;
    wire zq_go = is_zq && cmd_ok;
    // Back-to-back pattern reads are refused while a burst is still out
    wire rd_busy = is_read && mpr_on && (st_q != DMZ_ST_IDLE);
    wire rd_rsv = is_read && mpr_on && !pat_ok; // reserved_encoding select
    wire cal_go = is_read && mpr_on && pat_ok && (st_q == DMZ_ST_IDLE) && cmd_ok;
    wire arr_go = is_read && !mpr_on && cmd_ok;
    wire err_d = quiet_viol || (is_mrs && ba[2]) || rd_busy || rd_rsv;

    // ----------------------------------------------------------------
    // Mode register set with delayed effect
    // ----------------------------------------------------------------
    // An older staged value is committed early when a new one arrives
    wire apply = (mod_cnt_q == 10'h001) || (mrs_go && mod_cnt_q != 10'h000);
    wire [9:0] mrd_cnt_d = mrs_go ? 10'(TMRD_CK) : dec_sat(mrd_cnt_q);
    wire [9:0] mod_cnt_d = mrs_go ? 10'(TMOD_CK) : dec_sat(mod_cnt_q);
    wire [9:0] zq_load = (cmd == DMZ_CMD_ZQCL) ?
        (zq_init_done_q ? 10'(TZQOPER_CK) : 10'(TZQINIT_CK)) : 10'(TZQCS_CK);
    wire [9:0] zq_cnt_d = zq_go ? zq_load : dec_sat(zq_cnt_q);

    // Timers and staged value
    always_ff @(posedge clk) begin
        if (rst) begin
            mrd_cnt_q <= 10'h000;
            mod_cnt_q <= 10'h000;
            zq_cnt_q <= 10'h000;
            pend_sel_q <= 2'h0;
            pend_val_q <= `DMZ_MR_RESET;
            zq_init_done_q <= 1'b0;
            mode_busy_q <= 1'b0;
            zq_busy_q <= 1'b0;
        end else begin
            mrd_cnt_q <= mrd_cnt_d;
            mod_cnt_q <= mod_cnt_d;
            zq_cnt_q <= zq_cnt_d;
            mode_busy_q <= (mrd_cnt_d != 10'h000) || (mod_cnt_d != 10'h000);
            zq_busy_q <= (zq_cnt_d != 10'h000);
            if (mrs_go) begin
                pend_sel_q <= ba[1:0];
                pend_val_q <= addr;
            end
            if (zq_go && cmd == DMZ_CMD_ZQCL) begin
                zq_init_done_q <= 1'b1;
            end
        end
    end

    // Mode registers; reset clears pattern mode as well
    always_ff @(posedge clk) begin
        if (rst) begin
            mr0_q <= `DMZ_MR_RESET;
            mr1_q <= `DMZ_MR_RESET;
            mr2_q <= `DMZ_MR_RESET;
            mr3_q <= `DMZ_MR_RESET;
        end else if (apply) begin
            case (pend_sel_q)
                2'h0: mr0_q <= pend_val_q;
                2'h1: mr1_q <= pend_val_q;
                2'h2: mr2_q <= pend_val_q;
                2'h3: mr3_q <= pend_val_q;
                default: mr0_q <= pend_val_q;
            endcase
        end
    end

    // Command status pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            array_rd_q <= 1'b0;
            cmd_err_q <= 1'b0;
        end else begin
            array_rd_q <= arr_go;
            cmd_err_q <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // Pattern burst generator
    // ----------------------------------------------------------------
    wire gen_valid = (st_q == DMZ_ST_BURST);
    wire gen_ready = !skid_v_q;
    wire in_fire = gen_valid && gen_ready;
    // Each beat drives every data line with the selected pattern bit
    wire [7:0] cal_pat = `DMZ_CAL_PATTERN;
    wire [7:0] gen_data = {8{cal_pat[beat_q]}};
    wire bc4 = !addr[`DMZ_A_BL8];
    wire [2:0] start_beat = (bc4 && addr[`DMZ_A_BC4_HI]) ? 3'h4 : 3'h0;
    wire [2:0] end_beat = (bc4 && !addr[`DMZ_A_BC4_HI]) ? 3'h3 : 3'h7;
    // Latency below two is clamped; the buffer stage costs one cycle
    wire [4:0] rl_load = (rl_cycles < 5'h2) ? 5'h1 : rl_cycles - 5'h1;

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= DMZ_ST_IDLE;
            rl_cnt_q <= 5'h00;
            beat_q <= 3'h0;
            last_q <= 3'h0;
        end else begin
            case (st_q)
                DMZ_ST_IDLE: begin
                    if (cal_go) begin
                        st_q <= DMZ_ST_WAIT;
                        rl_cnt_q <= rl_load;
                        beat_q <= start_beat;
                        last_q <= end_beat;
                    end
                end
                DMZ_ST_WAIT: begin
                    if (rl_cnt_q <= 5'h1) begin
                        st_q <= DMZ_ST_BURST;
                    end else begin
                        rl_cnt_q <= rl_cnt_q - 5'h1;
                    end
                end
                DMZ_ST_BURST: begin
                    // Beats leave in ascending order; a stall holds position
                    if (in_fire) begin
                        beat_q <= beat_q + 3'h1;
                        if (beat_q == last_q) begin
                            st_q <= DMZ_ST_IDLE;
                        end
                    end
                end
                default: st_q <= DMZ_ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Two-entry output buffer
    // ----------------------------------------------------------------
    // Output entry refills whenever it is empty or being taken
    wire out_take = !dq_valid_q || dq_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            dq_valid_q <= 1'b0;
            dq_q <= 8'h00;
            skid_v_q <= 1'b0;
            skid_q <= 8'h00;
        end else if (out_take) begin
            if (skid_v_q) begin
                dq_q <= skid_q;
                dq_valid_q <= 1'b1;
                skid_v_q <= 1'b0;
            end else begin
                dq_q <= gen_data;
                dq_valid_q <= in_fire;
            end
        end else if (in_fire) begin
            // Receiver stalled: park the beat so nothing is lost
            skid_v_q <= 1'b1;
            skid_q <= gen_data;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    localparam int A_MOD_DLY = TMOD_CK + 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_mr3_update_time: assert property (
        (mrs_go && ba == 3'h3 && mod_cnt_q == 10'h000 && mrd_cnt_q == 10'h000)
        |-> ##A_MOD_DLY (mr3_q == $past(addr, A_MOD_DLY)))
        else $error("mode register three not updated after mode delay");
    a_mrs_lockout: assert property (
        mrs_go ##1 !is_nop |-> ##1 cmd_err_q)
        else $error("command right after mode set not flagged");
    a_bc4_upper_half: assert property (
        cal_go && bc4 && addr[2] |=> beat_q == 3'h4 && last_q == 3'h7)
        else $error("upper chop burst starts at wrong position");
    a_bl8_from_zero: assert property (
        cal_go && !bc4 && addr[2:0] == 3'h0 |=> beat_q == 3'h0 && last_q == 3'h7)
        else $error("full burst does not span positions 0 to 7");
    a_beat_lsb_first: assert property (
        in_fire && beat_q == 3'h0 |-> gen_data == 8'h00)
        else $error("burst position 0 does not carry the low bit");
    a_read_latency: assert property (
        cal_go && rl_cycles == 5'h5 |-> ##5 (st_q == DMZ_ST_BURST))
        else $error("pattern burst not ready at read latency");
    a_zq_quiet: assert property (
        zq_cnt_q != 10'h000 && !is_nop && !is_zq |=> cmd_err_q)
        else $error("activity during calibration not flagged");
    a_zq_short_len: assert property (
        zq_go && cmd == DMZ_CMD_ZQCS |=> zq_cnt_q == 10'(TZQCS_CK) && zq_busy_q)
        else $error("short calibration interval wrong");
    a_mpr_write_block: assert property (
        mpr_on && cmd == DMZ_CMD_WRITE |=> cmd_err_q && !array_rd_q)
        else $error("write in pattern mode not refused");
    a_normal_read: assert property (
        arr_go |=> array_rd_q && st_q == $past(st_q))
        else $error("normal read not sent to array");
    a_stall_holds: assert property (
        dq_valid_q && !dq_ready |=> dq_valid_q && $stable(dq_q))
        else $error("stalled output word changed");

    c_bl8_read: cover property (cal_go && !bc4);
    c_bc4_upper: cover property (cal_go && bc4 && addr[2]);
    c_zq_long: cover property (zq_go && cmd == DMZ_CMD_ZQCL);
    c_buffer_full: cover property (skid_v_q && !dq_ready);
endmodule // dmz_mode_ctl

// >>> logic/dmz_defs.svh
`ifndef DMZ_DEFS_SVH
`define DMZ_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define DMZ_CK_PS 5000
`define DMZ_TMOD_NS 15
`define DMZ_TMOD_CK (((`DMZ_TMOD_NS * 1000) + `DMZ_CK_PS - 1) / `DMZ_CK_PS)
`define DMZ_TMRD_CK 4
`define DMZ_TZQINIT_CK 512
`define DMZ_TZQOPER_CK 256
`define DMZ_TZQCS_CK 64

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define DMZ_MPR_EN_BIT 2
`define DMZ_MPR_SEL_PAT 2'h0
`define DMZ_MR_RESET 14'h0000
`define DMZ_CAL_PATTERN 8'haa
`define DMZ_A_BC4_HI 2
`define DMZ_A_BL8 12

`endif

// >>> logic/dmz_pkg.sv
// ----------------------------------------------------------------
// Types shared by the mode / pattern / calibration block
// ----------------------------------------------------------------
package dmz_pkg;
    // Decoded command from the controller
    typedef enum logic [2:0] {
        DMZ_CMD_NOP = 3'h0,
        DMZ_CMD_MRS = 3'h1,
        DMZ_CMD_READ = 3'h2,
        DMZ_CMD_RDAP = 3'h3,
        DMZ_CMD_WRITE = 3'h4,
        DMZ_CMD_ZQCL = 3'h5,
        DMZ_CMD_ZQCS = 3'h6,
        DMZ_CMD_OTHER = 3'h7
    } dmz_cmd_t;

    // Pattern burst generator, Gray along idle -> wait -> burst
    typedef enum logic [1:0] {
        DMZ_ST_IDLE = 2'h0,
        DMZ_ST_WAIT = 2'h1,
        DMZ_ST_BURST = 2'h3
    } dmz_state_t;
endpackage

// >>> testbench/dmz_ctl_model.sv
`timescale 1ns/10ps
// ------------------------------------------
// Controller model on the command side
// ------------------------------------------
module dmz_ctl_model (
    input wire logic clk,
    input wire logic mode_busy_q,
    input wire logic zq_busy_q,
    output dmz_pkg::dmz_cmd_t cmd,
    output logic [2:0] ba,
    output logic [13:0] addr,
    output logic dq_ready
);
    import dmz_pkg::*;
    logic stall = 1'b0; // Receiver stalls every other cycle when set
    // Idle bus at time zero; banks are taken as precharged throughout
    // Clock enable counts as held high and termination as off; a single rank
    // hangs on this model, and a calibration command inside a span restarts its count
    initial begin
        cmd = DMZ_CMD_NOP;
        ba = 3'h0;
        addr = 14'h0000;
        dq_ready = 1'b1;
    end
    // Receiver readiness, toggled to exercise the two-entry buffer
    always @(posedge clk) begin
        #1 dq_ready = stall ? ~dq_ready : 1'b1;
    end
    // One command for one cycle; legal callers wait out the busy windows
    task automatic send(input dmz_cmd_t c, input logic [2:0] b, input logic [13:0] a,
                        input logic wait_idle);
        int n;
        n = 0;
        // Busy flags are read off the edge so the update at that edge has settled
        while (wait_idle && (mode_busy_q || zq_busy_q) && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        #1;
        cmd = c;
        ba = b;
        addr = a;
        @(posedge clk);
        #1;
        // Released lines show the inverse so a stale value cannot pass
        cmd = DMZ_CMD_NOP;
        ba = ~b;
        addr = ~a;
    endtask
endmodule // dmz_ctl_model

// >>> testbench/tb.sv
`timescale 1ns/10ps
module tb;
    import dmz_pkg::*;
    localparam int RL = 5; // Read latency handed to the block
    localparam int TZI = 8; // Shortened calibration counts keep the run brief
    localparam int TZO = 6;
    localparam int TZS = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dmz_cmd_t cmd;
    logic [2:0] ba;
    logic [13:0] addr, mr0_q, mr1_q, mr2_q, mr3_q;
    logic dq_ready, mode_busy_q, zq_busy_q, array_rd_q, cmd_err_q, dq_valid_q;
    logic [7:0] dq_q;
    int error_cnt = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    dmz_mode_ctl #(.TMRD_CK(4), .TMOD_CK(3), .TZQINIT_CK(TZI), .TZQOPER_CK(TZO),
        .TZQCS_CK(TZS)) i_dut (.clk(clk), .rst(rst), .cmd(cmd), .ba(ba), .addr(addr),
        .rl_cycles(5'h05), .dq_ready(dq_ready), .mr0_q(mr0_q), .mr1_q(mr1_q),
        .mr2_q(mr2_q), .mr3_q(mr3_q), .mode_busy_q(mode_busy_q), .zq_busy_q(zq_busy_q),
        .array_rd_q(array_rd_q), .cmd_err_q(cmd_err_q), .dq_q(dq_q), .dq_valid_q(dq_valid_q));
    dmz_ctl_model i_ctl (.clk(clk), .mode_busy_q(mode_busy_q), .zq_busy_q(zq_busy_q),
        .cmd(cmd), .ba(ba), .addr(addr), .dq_ready(dq_ready));
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Issue a command and look at its one-cycle answer
    task automatic op(input dmz_cmd_t c, input logic [2:0] b, input logic [13:0] a,
                      input logic w, input logic err, input logic rd);
        i_ctl.send(c, b, a, w);
        check(cmd_err_q, err, "refusal");
        check(array_rd_q, rd, "array read");
    endtask
    task automatic idle;
        int n;
        n = 0;
        while ((mode_busy_q || zq_busy_q) && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    // Pattern read: latency, beat count and beat values
    task automatic burst(input dmz_cmd_t c, input logic [13:0] a, input int first,
                         input int n, input logic lat);
        int k, got;
        k = 0;
        got = 0;
        op(c, 3'h0, a, 1'b1, 1'b0, 1'b0);
        while (dq_valid_q !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1 k++;
        end
        if (lat) check(k, RL, "latency");
        while (got < n && k < 80) begin
            @(negedge clk);
            k++;
            if (dq_valid_q === 1'b1 && dq_ready === 1'b1) begin
                check(dq_q, ((first + got) % 2) ? 8'hff : 8'h00, "beat");
                got++;
            end
        end
        @(negedge clk);
        check(got, n, "beat count");
        check(dq_valid_q, 1'b0, "extra beat");
    endtask
    task automatic zq_len(input int exp);
        int n;
        n = 0;
        while (zq_busy_q === 1'b1 && n < 600) begin
            @(posedge clk);
            #1 n++;
        end
        check(n, exp, "calibration span");
    endtask
    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        check({mode_busy_q, zq_busy_q, array_rd_q, cmd_err_q, dq_valid_q, dq_q}, 16'h0000,
              "reset");
        check(mr3_q, 14'h0000, "mr3 reset");
        for (int i = 0; i < 3; i++) begin
            op(DMZ_CMD_MRS, i[2:0], 14'h2a50 | 14'(i), 1'b1, 1'b0, 1'b0);
        end
        op(DMZ_CMD_MRS, 3'h4, 14'h0004, 1'b1, 1'b1, 1'b0);
        op(DMZ_CMD_READ, 3'h0, 14'h1000, 1'b1, 1'b0, 1'b1);
        op(DMZ_CMD_MRS, 3'h3, 14'h0004, 1'b1, 1'b0, 1'b0);
        check(mr3_q, 14'h0000, "early apply");
        check(mode_busy_q, 1'b1, "mode busy");
        op(DMZ_CMD_MRS, 3'h2, 14'h0000, 1'b0, 1'b1, 1'b0);
        idle();
        check(mr0_q, 14'h2a50, "mr0");
        check(mr1_q, 14'h2a51, "mr1");
        check(mr2_q, 14'h2a52, "mr2");
        check(mr3_q, 14'h0004, "mr3");
        burst(DMZ_CMD_READ, 14'h1000, 0, 8, 1'b1);
        i_ctl.stall = 1'b1;
        burst(DMZ_CMD_RDAP, 14'h0000, 0, 4, 1'b0);
        burst(DMZ_CMD_READ, 14'h0004, 4, 4, 1'b0);
        i_ctl.stall = 1'b0;
        op(DMZ_CMD_WRITE, 3'h0, 14'h0000, 1'b1, 1'b1, 1'b0);
        op(DMZ_CMD_OTHER, 3'h0, 14'h0000, 1'b1, 1'b1, 1'b0);
        for (int s = 1; s < 4; s++) begin
            op(DMZ_CMD_MRS, 3'h3, 14'h0004 | 14'(s), 1'b1, 1'b0, 1'b0);
            op(DMZ_CMD_READ, 3'h0, 14'h1000, 1'b1, 1'b1, 1'b0);
        end
        op(DMZ_CMD_MRS, 3'h3, 14'h0003, 1'b1, 1'b0, 1'b0);
        op(DMZ_CMD_READ, 3'h0, 14'h1000, 1'b1, 1'b0, 1'b1);
        op(DMZ_CMD_ZQCL, 3'h0, 14'h0000, 1'b1, 1'b0, 1'b0);
        zq_len(TZI);
        op(DMZ_CMD_ZQCL, 3'h0, 14'h0000, 1'b1, 1'b0, 1'b0);
        zq_len(TZO);
        op(DMZ_CMD_ZQCL, 3'h0, 14'h0000, 1'b1, 1'b0, 1'b0);
        op(DMZ_CMD_ZQCS, 3'h0, 14'h0000, 1'b0, 1'b0, 1'b0);
        zq_len(TZS);
        op(DMZ_CMD_ZQCS, 3'h0, 14'h0000, 1'b1, 1'b0, 1'b0);
        op(DMZ_CMD_READ, 3'h0, 14'h1000, 1'b0, 1'b1, 1'b0);
        idle();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        check(mr0_q, 14'h0000, "mr0 after reset");
        op(DMZ_CMD_ZQCL, 3'h0, 14'h0000, 1'b1, 1'b0, 1'b0);
        zq_len(TZI);
        give_verdict();
    end
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end
endmodule // tb
